// ==== hw/stack_link_pkg.sv ====
package stack_link_pkg;
  localparam int CLK_HZ = 125_000_000;
  localparam int BAUD_RATE = 9600;
  // Bit period rounded down; error stays well under a percent
  localparam int BIT_CYCLES = CLK_HZ / BAUD_RATE;
  localparam int DATA_BITS = 8;
  localparam int CNT_W = 16;
  localparam logic [7:0] QUALITY_SERIAL = 8'hff;
  localparam logic [7:0] QUALITY_RADIO = 8'h46;
  localparam logic [7:0] CTRL_C = 8'h03;
  localparam logic [1:0] ESCAPE_LEN = 2'h3;

  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } frame_beat_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rx_beat_t;

  typedef enum {ARB_IDLE, ARB_CHECK, ARB_SEND, ARB_RELEASE} arb_state_t;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
  typedef enum {TX_IDLE, TX_SHIFT} tx_state_t;
endpackage

// ==== hw/serial_byte_tx.sv ====
module serial_byte_tx
  import stack_link_pkg::*;
#(
  parameter int BIT_LEN = BIT_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [7:0] data,
  output logic busy,
  output logic txd
);
  tx_state_t state, next_state;
  logic [9:0] shift, next_shift;
  logic [3:0] bits, next_bits;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic next_busy, next_txd;

  // Start bit, eight data bits LSB first, one stop bit
  always_comb begin
    next_state = state;
    next_shift = shift;
    next_bits = bits;
    next_cnt = cnt;
    next_busy = busy;
    next_txd = txd;
    unique case (state)
      TX_IDLE: begin
        next_txd = 1'b1;
        if (start) begin
          next_shift = {1'b1, data, 1'b0};
          next_bits = 4'h0;
          next_cnt = CNT_W'(BIT_LEN - 1);
          next_busy = 1'b1;
          next_txd = 1'b0;
          next_state = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        if (cnt != '0) begin
          next_cnt = cnt - 1'b1;
        end else if (bits == 4'h9) begin
          next_busy = 1'b0;
          next_txd = 1'b1;
          next_state = TX_IDLE;
        end else begin
          next_shift = {1'b1, shift[9:1]};
          next_txd = shift[1];
          next_bits = bits + 1'b1;
          next_cnt = CNT_W'(BIT_LEN - 1);
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= TX_IDLE;
      shift <= '1;
      bits <= 4'h0;
      cnt <= '0;
      busy <= 1'b0;
      txd <= 1'b1;
    end else begin
      state <= next_state;
      shift <= next_shift;
      bits <= next_bits;
      cnt <= next_cnt;
      busy <= next_busy;
      txd <= next_txd;
    end
  end
endmodule

// ==== hw/serial_stack_link_arbiter.sv ====
module serial_stack_link_arbiter
  import stack_link_pkg::*;
#(
  parameter int BIT_LEN = BIT_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic interface_mode_select,
  input wire logic large_stack,
  input wire logic rxd,
  input wire logic rts,
  input wire frame_beat_t tx_in,
  output logic tx_ready,
  output logic txd,
  output logic cts,
  output rx_beat_t net_rx,
  output rx_beat_t cmd_rx,
  output logic net_mode,
  output logic [7:0] quality_serial,
  output logic [7:0] quality_radio
);
  logic mode_meta, mode_sync, rts_meta, rts_sync, rxd_meta, rxd_sync;
  // Synchronisers stay unreset so the strap is valid at release
  always_ff @(posedge clk) begin
    mode_meta <= interface_mode_select;
    mode_sync <= mode_meta;
    rts_meta <= rts;
    rts_sync <= rts_meta;
    rxd_meta <= rxd;
    rxd_sync <= rxd_meta;
  end

  // Mode and escape
  logic mode_captured, next_mode_captured, next_net_mode;
  logic [1:0] ctrl_c_count, next_ctrl_c_count;
  logic rx_done;
  logic [7:0] rx_byte;
  logic escape_hit;
  rx_beat_t next_net_rx, next_cmd_rx;

  assign escape_hit = rx_done && net_mode && rx_byte == CTRL_C && ctrl_c_count == ESCAPE_LEN - 2'h1;

  always_comb begin
    next_mode_captured = 1'b1;
    next_net_mode = net_mode;
    next_ctrl_c_count = ctrl_c_count;
    next_net_rx = '0;
    next_cmd_rx = '0;
    // Strap read once after reset; later changes wait for power cycle
    if (!mode_captured) begin
      next_net_mode = mode_sync;
    end
    if (rx_done) begin
      if (net_mode) begin
        next_net_rx = '{valid: 1'b1, data: rx_byte};
        next_ctrl_c_count = (rx_byte == CTRL_C) ? ctrl_c_count + 2'h1 : 2'h0;
        if (escape_hit) begin
          next_net_mode = 1'b0;
          next_ctrl_c_count = 2'h0;
        end
      end else begin
        next_cmd_rx = '{valid: 1'b1, data: rx_byte};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mode_captured <= 1'b0;
      net_mode <= 1'b0;
      ctrl_c_count <= 2'h0;
      net_rx <= '0;
      cmd_rx <= '0;
      quality_serial <= QUALITY_SERIAL;
      quality_radio <= QUALITY_RADIO;
    end else begin
      mode_captured <= next_mode_captured;
      net_mode <= next_net_mode;
      ctrl_c_count <= next_ctrl_c_count;
      net_rx <= next_net_rx;
      cmd_rx <= next_cmd_rx;
    end
  end

  // Receiver, 8N1, sampled mid-bit
  rx_state_t rx_state, next_rx_state;
  logic [CNT_W-1:0] rx_cnt, next_rx_cnt;
  logic [2:0] rx_bits, next_rx_bits;
  logic [7:0] next_rx_byte;
  logic next_rx_done;

  always_comb begin
    next_rx_state = rx_state;
    next_rx_cnt = rx_cnt;
    next_rx_bits = rx_bits;
    next_rx_byte = rx_byte;
    next_rx_done = 1'b0;
    unique case (rx_state)
      RX_IDLE: begin
        if (!rxd_sync) begin
          next_rx_cnt = CNT_W'(BIT_LEN / 2);
          next_rx_state = RX_START;
        end
      end
      RX_START: begin
        if (rx_cnt != '0) begin
          next_rx_cnt = rx_cnt - 1'b1;
        end else if (rxd_sync) begin
          next_rx_state = RX_IDLE; // Glitch, not a start bit
        end else begin
          next_rx_cnt = CNT_W'(BIT_LEN - 1);
          next_rx_bits = 3'h0;
          next_rx_state = RX_DATA;
        end
      end
      RX_DATA: begin
        if (rx_cnt != '0) begin
          next_rx_cnt = rx_cnt - 1'b1;
        end else begin
          next_rx_byte = {rxd_sync, rx_byte[7:1]};
          next_rx_cnt = CNT_W'(BIT_LEN - 1);
          next_rx_bits = rx_bits + 3'h1;
          if (rx_bits == 3'h7) begin
            next_rx_state = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (rx_cnt != '0) begin
          next_rx_cnt = rx_cnt - 1'b1;
        end else begin
          // Framing error drops the byte
          next_rx_done = rxd_sync;
          next_rx_state = RX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_state <= RX_IDLE;
      rx_cnt <= '0;
      rx_bits <= 3'h0;
      rx_byte <= 8'h00;
      rx_done <= 1'b0;
    end else begin
      rx_state <= next_rx_state;
      rx_cnt <= next_rx_cnt;
      rx_bits <= next_rx_bits;
      rx_byte <= next_rx_byte;
      rx_done <= next_rx_done;
    end
  end

  // Link access
  arb_state_t state, next_state;
  logic start, next_start, tx_busy, last_taken, next_last_taken;
  logic [7:0] tx_byte, next_tx_byte;
  logic next_cts, next_tx_ready;
  logic arbitrate;

  assign arbitrate = net_mode && large_stack;

  always_comb begin
    next_state = state;
    next_cts = cts;
    next_start = 1'b0;
    next_tx_byte = tx_byte;
    next_last_taken = last_taken;
    unique case (state)
      ARB_IDLE: begin
        next_cts = 1'b1;
        next_last_taken = 1'b0;
        if (tx_in.valid) begin
          next_state = arbitrate ? ARB_CHECK : ARB_SEND;
        end
      end
      ARB_CHECK: begin
        // Two nodes seeing the link free together can still collide
        if (rts_sync) begin
          next_cts = 1'b0;
          next_state = ARB_SEND;
        end
      end
      ARB_SEND: begin
        if (tx_ready && tx_in.valid) begin
          next_start = 1'b1;
          next_tx_byte = tx_in.data;
          next_last_taken = tx_in.last;
        end else if (last_taken && !start && !tx_busy) begin
          next_state = ARB_RELEASE;
        end
      end
      ARB_RELEASE: begin
        next_cts = 1'b1;
        next_state = ARB_IDLE;
      end
    endcase
    next_tx_ready = next_state == ARB_SEND && !next_last_taken && !next_start && !start && !tx_busy;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= ARB_IDLE;
      cts <= 1'b1;
      start <= 1'b0;
      tx_byte <= 8'h00;
      last_taken <= 1'b0;
      tx_ready <= 1'b0;
    end else begin
      state <= next_state;
      cts <= next_cts;
      start <= next_start;
      tx_byte <= next_tx_byte;
      last_taken <= next_last_taken;
      tx_ready <= next_tx_ready;
    end
  end

  serial_byte_tx #(.BIT_LEN(BIT_LEN)) u_tx (
    .clk(clk),
    .reset(reset),
    .start(start),
    .data(tx_byte),
    .busy(tx_busy),
    .txd(txd)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_claim;
    state == ARB_CHECK && rts_sync;
  endsequence

  sequence s_frame_done;
    state == ARB_SEND && last_taken && !start && !tx_busy && !(tx_ready && tx_in.valid);
  endsequence

  claim_needs_rts_a: assert property ($fell(cts) |-> $past(rts_sync))
    else $error("Link claimed without free request line");
  claim_then_send_a: assert property (s_claim |=> !cts && state == ARB_SEND)
    else $error("Claim did not lower clear-to-send");
  send_held_claim_a: assert property (start && $past(arbitrate) && arbitrate |-> !cts)
    else $error("Byte started without holding the link");
  small_stack_free_a: assert property (state == ARB_IDLE && tx_in.valid && !arbitrate |=> state == ARB_SEND)
    else $error("Small stack waited for arbitration");
  release_link_a: assert property (s_frame_done |=> state == ARB_RELEASE ##1 cts)
    else $error("Link not released after frame");
  mode_at_boot_a: assert property ($rose(net_mode) |-> !$past(mode_captured))
    else $error("Mode changed without power cycle");
  escape_exit_a: assert property (escape_hit |=> !net_mode ##1 !net_mode)
    else $error("Escape did not leave stacking mode");
  no_cmd_in_net_a: assert property (cmd_rx.valid |-> !$past(net_mode, 2))
    else $error("Command byte delivered in stacking mode");
  quality_default_a: assert property (quality_serial == 8'hff && quality_radio == 8'h46)
    else $error("Route quality defaults wrong");
endmodule

// ==== testbench/stack_peer_model.sv ====
module stack_peer_model
  import stack_link_pkg::*;
#(
  parameter int BIT_LEN = 16
) (
  input wire logic clk,
  input wire logic cts,
  output logic rts,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic claim = 1'b0;
  // Any peer holding the link pulls the device's request line low
  assign rts = ~claim;
  initial rxd = 1'b1;
  // A peer only claims while the device leaves the link free
  task automatic hold_link(input logic on);
    @(negedge clk);
    claim = on & cts;
  endtask
  // Crossed cable: peer transmit drives the device receive pin
  task automatic send_serial(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk);
      rxd = f[i];
      repeat (BIT_LEN - 1) @(negedge clk);
    end
  endtask
endmodule

// ==== testbench/tb.sv ====
`define CHECK(name, exp, got) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("MISMATCH %s expected %h seen %h", name, exp, got); \
    end \
  end
module tb
  import stack_link_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BL = 16;
  logic clk, reset, interface_mode_select, large_stack, rxd, rts, tx_ready, txd, cts, net_mode;
  frame_beat_t tx_in;
  rx_beat_t net_rx, cmd_rx;
  logic [7:0] quality_serial, quality_radio, net_last, cmd_last;
  int mismatches = 0, cmp_count = 0, net_n = 0, cmd_n = 0;

  serial_stack_link_arbiter #(.BIT_LEN(BL)) serial_stack_link_arbiter_inst (.clk(clk), .reset(reset),
    .interface_mode_select(interface_mode_select), .large_stack(large_stack), .rxd(rxd), .rts(rts),
    .tx_in(tx_in), .tx_ready(tx_ready), .txd(txd), .cts(cts), .net_rx(net_rx), .cmd_rx(cmd_rx),
    .net_mode(net_mode), .quality_serial(quality_serial), .quality_radio(quality_radio));
  stack_peer_model #(.BIT_LEN(BL)) stack_peer_model_inst (.clk(clk), .cts(cts), .rts(rts), .rxd(rxd));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (net_rx.valid === 1'b1) begin
      net_n++;
      net_last = net_rx.data;
    end
    if (cmd_rx.valid === 1'b1) begin
      cmd_n++;
      cmd_last = cmd_rx.data;
    end
  end

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic do_reset;
    reset = 1'b1;
    repeat (10) @(negedge clk);
    reset = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task automatic peer_byte(input logic [7:0] b);
    stack_peer_model_inst.send_serial(b);
    repeat (4) @(negedge clk);
  endtask
  task automatic put_byte(input logic [7:0] d, input logic l);
    int n;
    n = 0;
    tx_in = '{valid: 1'b1, last: l, data: d};
    while (tx_ready !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    tx_in.valid = 1'b0;
    `CHECK("tx byte taken", 1'b1, n < 400)
  endtask
  task automatic get_txd(output logic [7:0] b, output logic c);
    int n;
    n = 0;
    while (txd !== 1'b0 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    c = cts;
    repeat (BL / 2) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BL) @(negedge clk);
      b[i] = txd;
    end
    repeat (BL) @(negedge clk);
    `CHECK("stop bit", 1'b1, txd)
  endtask
  task automatic tx_frame(input logic [7:0] a, input logic [7:0] b, input logic exp_cts);
    logic [7:0] g;
    logic c;
    fork put_byte(a, 1'b0); get_txd(g, c); join
    `CHECK("tx first byte", a, g)
    `CHECK("cts at first start bit", exp_cts, c)
    fork put_byte(b, 1'b1); get_txd(g, c); join
    `CHECK("tx last byte", b, g)
    `CHECK("cts at last start bit", exp_cts, c)
    repeat (BL + 4) @(negedge clk);
    `CHECK("cts after frame", 1'b1, cts)
  endtask

  task automatic t_startup;
    interface_mode_select = 1'b0;
    do_reset();
    `CHECK("quality serial", 8'hff, quality_serial)
    `CHECK("quality radio", 8'h46, quality_radio)
    `CHECK("idle txd", 1'b1, txd)
    `CHECK("idle cts", 1'b1, cts)
    interface_mode_select = 1'b1;
    repeat (5) @(negedge clk);
    `CHECK("mode without power cycle", 1'b0, net_mode)
    peer_byte(8'h41);
    `CHECK("terminal byte count", 1, cmd_n)
    `CHECK("terminal byte", 8'h41, cmd_last)
    $display("test startup done");
  endtask
  task automatic t_net_mode;
    do_reset();
    `CHECK("mode after power cycle", 1'b1, net_mode)
    peer_byte(8'h5a);
    `CHECK("net byte count", 1, net_n)
    `CHECK("net byte", 8'h5a, net_last)
    `CHECK("no terminal byte", 1, cmd_n)
    $display("test net mode done");
  endtask
  task automatic t_small_stack;
    large_stack = 1'b0;
    stack_peer_model_inst.hold_link(1'b1);
    tx_frame(8'ha5, 8'h01, 1'b1);
    stack_peer_model_inst.hold_link(1'b0);
    $display("test small stack done");
  endtask
  task automatic t_arbitrate;
    logic seen;
    seen = 1'b0;
    large_stack = 1'b1;
    stack_peer_model_inst.hold_link(1'b1);
    // Peer claim needs two edges through the request synchroniser
    repeat (3) @(negedge clk);
    tx_in = '{valid: 1'b1, last: 1'b0, data: 8'h3c};
    repeat (60) begin
      @(negedge clk);
      seen = seen | tx_ready | ~cts | ~txd;
    end
    `CHECK("blocked while link busy", 1'b0, seen)
    stack_peer_model_inst.hold_link(1'b0);
    tx_frame(8'h3c, 8'h80, 1'b0);
    $display("test arbitration done");
  endtask
  task automatic t_escape;
    peer_byte(8'h03);
    peer_byte(8'h03);
    peer_byte(8'h41);
    peer_byte(8'h03);
    peer_byte(8'h03);
    `CHECK("broken escape keeps mode", 1'b1, net_mode)
    peer_byte(8'h03);
    `CHECK("escape bytes on net side", 7, net_n)
    `CHECK("escape leaves net mode", 1'b0, net_mode)
    peer_byte(8'h42);
    `CHECK("terminal after escape", 8'h42, cmd_last)
    `CHECK("terminal count after escape", 2, cmd_n)
    $display("test escape done");
  endtask

  initial begin
    reset = 1'b1;
    interface_mode_select = 1'b0;
    large_stack = 1'b0;
    tx_in = '0;
    t_startup();
    t_net_mode();
    t_small_stack();
    t_arbitrate();
    t_escape();
    report_and_stop();
  end
  // Whole run needs a few thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end
endmodule
